// >>> logic/hdc_pkg.sv
package hdc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] DRIVE_CONTROL_ONE_ADDR = 8'h1B;
    localparam logic [7:0] DRIVE_CONTROL_TWO_ADDR = 8'h1C;

    // ==========================================================
    // Field positions
    localparam int BOOST_BIT     = 7;
    localparam int RESERVED_BIT  = 6;
    localparam int BIAS_BIT      = 5;
    localparam int DTIME_MSB     = 4;
    localparam int DIR_BIT       = 7;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DRIVE_CONTROL_ONE_RST = 8'h93;
    localparam logic [7:0] DRIVE_CONTROL_TWO_RST = 8'hF5;

    // ==========================================================
    // Timing, in nanoseconds, and clock period
    localparam int CLK_PERIOD_NS = 8;
    localparam int LRA_STEP_NS   = 100000;
    localparam int LRA_BASE_NS   = 500000;
    localparam int ERM_STEP_NS   = 200000;
    localparam int ERM_BASE_NS   = 1000000;

    // Cycle counts derived from the times above
    localparam int LRA_STEP_CYC  = LRA_STEP_NS / CLK_PERIOD_NS;
    localparam int LRA_BASE_CYC  = LRA_BASE_NS / CLK_PERIOD_NS;
    localparam int ERM_STEP_CYC  = ERM_STEP_NS / CLK_PERIOD_NS;
    localparam int ERM_BASE_CYC  = ERM_BASE_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Widths and amplitude constants
    localparam int         CYC_W       = 24;
    localparam logic [7:0] AMP_MIDPOINT = 8'h80;
    localparam logic [CYC_W-1:0] TIMER_ZERO = 24'h000000;

endpackage

// >>> logic/hdc_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module hdc_interval_timer #(
    parameter int CYC_W = 24
) (
    input  wire logic             sys_clk,     // System clock
    input  wire logic             sys_rst,     // Asynchronous reset, active high
    input  wire logic [CYC_W-1:0] period_cyc,  // Interval length in cycles
    output logic                  tick         // One-cycle pulse per interval
);

    typedef struct packed {
        logic [CYC_W-1:0] cnt;
        logic             tick;
    } hdc_tmr_state_t;

    hdc_tmr_state_t st_r;
    hdc_tmr_state_t st_nxt;

    // ==========================================================
    // Free-running interval counter
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        // A shortened period takes effect at once rather than after a wrap
        if (st_r.cnt + 1'b1 >= period_cyc) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule

`default_nettype wire

// >>> logic/hdc_drive_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Boost bit set raises feedback loop gain during overdrive.
// - Bias bit one drives 0.9 V common mode onto trigger pin; zero disables.
// - Resonant drive time is field times 0.1 ms plus 0.5 ms; field resets 0x13.
// - Resonant drive time is only a start; runtime measurement then adjusts it.
// - Rotating-mass sample interval is field times 0.2 ms plus 1 ms.
// - Direction bit selects input interpretation; zero means unidirectional.
// - Unidirectional maps input linearly: zero none, half half, full full.
// - Unidirectional braking comes only from feedback conditions.
// - Unidirectional uses full range, one more amplitude bit than bidirectional.
// - Bidirectional open loop brakes below midpoint, driving output negative.
module hdc_drive_control_regs #(
    parameter int LRA_STEP_CYC = hdc_pkg::LRA_STEP_CYC,
    parameter int LRA_BASE_CYC = hdc_pkg::LRA_BASE_CYC,
    parameter int ERM_STEP_CYC = hdc_pkg::ERM_STEP_CYC,
    parameter int ERM_BASE_CYC = hdc_pkg::ERM_BASE_CYC
) (
    input  wire logic                     sys_clk,                // System clock
    input  wire logic                     sys_rst,                // Asynchronous reset, active high
    input  wire logic [7:0]               reg_addr,               // Register address from host bus
    input  wire logic [7:0]               reg_wdata,              // Write data
    input  wire logic                     reg_wr_en,              // Write strobe, one cycle
    input  wire logic                     reg_rd_en,              // Read strobe, one cycle
    output logic [7:0]                    reg_rdata,              // Read data, one cycle after strobe
    input  wire logic                     actuator_is_lra,        // 1 resonant, 0 rotating mass
    input  wire logic                     loop_closed,            // 1 closed loop, 0 open loop
    input  wire logic [hdc_pkg::CYC_W-1:0] lra_period_meas,       // Measured resonant period, cycles
    input  wire logic                     lra_period_valid,       // Strobe for measured period
    input  wire logic                     feedback_brake_req,     // Feedback says brake
    input  wire logic [7:0]               play_sample,            // Playback input sample
    output logic                          overdrive_gain_boost,   // High loop gain in overdrive
    output logic                          input_common_mode_bias, // Bias enable on trigger pin
    output logic                          input_direction_select, // 1 bidirectional input
    output logic [hdc_pkg::CYC_W-1:0]     drive_time_cyc,         // Active drive time or sample interval
    output logic                          drive_tick,             // Pulse per drive/sample interval
    output logic [7:0]                    drive_magnitude,        // Output amplitude
    output logic                          drive_negative,         // Output polarity negative
    output logic                          drive_brake             // Braking active
);

    localparam int W = hdc_pkg::CYC_W;

    typedef struct packed {
        logic         boost;
        logic         bias;
        logic [4:0]   dtime;
        logic [7:0]   ctl2;
        logic [7:0]   rdata;
        logic [W-1:0] lra_adj;
        logic         lra_adj_vld;
        logic [W-1:0] drive_cyc;
        logic [7:0]   mag;
        logic         neg;
        logic         brake;
    } hdc_regs_state_t;

    hdc_regs_state_t st_r;
    hdc_regs_state_t st_nxt;

    logic [W-1:0] lra_prog_cyc;
    logic [W-1:0] erm_prog_cyc;
    logic [7:0]   ctl1_view;

    // ==========================================================
    // Programmed times
    assign lra_prog_cyc = W'(st_r.dtime * LRA_STEP_CYC + LRA_BASE_CYC);
    assign erm_prog_cyc = W'(st_r.dtime * ERM_STEP_CYC + ERM_BASE_CYC);
    assign ctl1_view    = {st_r.boost, 1'b0, st_r.bias, st_r.dtime};

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;

        if (reg_wr_en && reg_addr == hdc_pkg::DRIVE_CONTROL_ONE_ADDR) begin
            st_nxt.boost       = reg_wdata[hdc_pkg::BOOST_BIT];
            st_nxt.bias        = reg_wdata[hdc_pkg::BIAS_BIT];
            st_nxt.dtime       = reg_wdata[hdc_pkg::DTIME_MSB:0];
            // A fresh estimate discards the tracked value
            st_nxt.lra_adj_vld = 1'b0;
        end else if (lra_period_valid) begin
            st_nxt.lra_adj     = {1'b0, lra_period_meas[W-1:1]};
            st_nxt.lra_adj_vld = 1'b1;
        end
        if (reg_wr_en && reg_addr == hdc_pkg::DRIVE_CONTROL_TWO_ADDR) begin
            st_nxt.ctl2 = reg_wdata;
        end

        if (reg_rd_en) begin
            case (reg_addr)
                hdc_pkg::DRIVE_CONTROL_ONE_ADDR: st_nxt.rdata = ctl1_view;
                hdc_pkg::DRIVE_CONTROL_TWO_ADDR: st_nxt.rdata = st_r.ctl2;
                default:                         st_nxt.rdata = 8'h00;
            endcase
        end

        if (actuator_is_lra) begin
            st_nxt.drive_cyc = st_r.lra_adj_vld ? st_r.lra_adj : lra_prog_cyc;
        end else begin
            st_nxt.drive_cyc = erm_prog_cyc;
        end
        if (st_nxt.drive_cyc == hdc_pkg::TIMER_ZERO) begin
            st_nxt.drive_cyc = lra_prog_cyc;
        end

        // Input interpretation
        if (!st_r.ctl2[hdc_pkg::DIR_BIT]) begin
            // Full range is positive, giving the extra amplitude bit
            st_nxt.mag   = play_sample;
            st_nxt.neg   = 1'b0;
            st_nxt.brake = feedback_brake_req;
        end else if (play_sample >= hdc_pkg::AMP_MIDPOINT) begin
            st_nxt.mag   = {7'(play_sample - hdc_pkg::AMP_MIDPOINT), 1'b0};
            st_nxt.neg   = 1'b0;
            st_nxt.brake = loop_closed & feedback_brake_req;
        end else if (loop_closed) begin
            st_nxt.mag   = 8'h00;
            st_nxt.neg   = 1'b0;
            st_nxt.brake = feedback_brake_req;
        end else begin
            // Zero input saturates to full scale; the 7-bit difference would wrap to zero
            st_nxt.mag   = (play_sample == 8'h00) ? 8'hFF
                         : {7'(hdc_pkg::AMP_MIDPOINT - play_sample), 1'b0};
            st_nxt.neg   = 1'b1;
            st_nxt.brake = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r             <= '0;
            st_r.boost       <= hdc_pkg::DRIVE_CONTROL_ONE_RST[hdc_pkg::BOOST_BIT];
            st_r.bias        <= hdc_pkg::DRIVE_CONTROL_ONE_RST[hdc_pkg::BIAS_BIT];
            st_r.dtime       <= hdc_pkg::DRIVE_CONTROL_ONE_RST[hdc_pkg::DTIME_MSB:0];
            st_r.ctl2        <= hdc_pkg::DRIVE_CONTROL_TWO_RST;
            st_r.drive_cyc   <= W'(LRA_BASE_CYC);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Interval pulse for drive half-period or back-EMF sampling
    hdc_interval_timer #(
        .CYC_W      (W)
    ) u_timer (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .period_cyc (st_r.drive_cyc),
        .tick       (drive_tick)
    );

    assign reg_rdata              = st_r.rdata;
    assign overdrive_gain_boost   = st_r.boost;
    assign input_common_mode_bias = st_r.bias;
    assign input_direction_select = st_r.ctl2[hdc_pkg::DIR_BIT];
    assign drive_time_cyc         = st_r.drive_cyc;
    assign drive_magnitude        = st_r.mag;
    assign drive_negative         = st_r.neg;
    assign drive_brake            = st_r.brake;

endmodule

`default_nettype wire

// >>> verif/hdc_drive_props.sv
`timescale 1ns/1ps
`default_nettype none
module hdc_drive_props #(
    parameter int ERM_STEP_CYC = 20,
    parameter int ERM_BASE_CYC = 100
) (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [7:0]  reg_rdata,
    input wire logic        actuator_is_lra,
    input wire logic        loop_closed,
    input wire logic        feedback_brake_req,
    input wire logic [7:0]  play_sample,
    input wire logic        overdrive_gain_boost,
    input wire logic        input_common_mode_bias,
    input wire logic        input_direction_select,
    input wire logic [23:0] drive_time_cyc,
    input wire logic [7:0]  drive_magnitude,
    input wire logic        drive_negative,
    input wire logic        drive_brake
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic wr1;
    assign wr1 = reg_wr_en && reg_addr == 8'h1B;
    boost_follow_a: assert property (wr1 |=> overdrive_gain_boost == $past(reg_wdata[7]))
        else $error("boost bit not applied");
    bias_follow_a: assert property (wr1 |=> input_common_mode_bias == $past(reg_wdata[5]))
        else $error("bias bit not applied");
    dir_follow_a: assert property (reg_wr_en && reg_addr == 8'h1C |=> input_direction_select == $past(reg_wdata[7]))
        else $error("direction bit not applied");
    rsv_zero_a: assert property (reg_rd_en && reg_addr == 8'h1B |=> !reg_rdata[6])
        else $error("reserved bit read nonzero");
    erm_time_a: assert property (wr1 && !actuator_is_lra ##1 !actuator_is_lra
        |=> drive_time_cyc == $past(reg_wdata[4:0], 2) * ERM_STEP_CYC + ERM_BASE_CYC)
        else $error("sample interval wrong");
    uni_map_a: assert property (!input_direction_select && !reg_wr_en
        |=> drive_magnitude == $past(play_sample) && !drive_negative)
        else $error("unidirectional mapping wrong");
    uni_brake_a: assert property (!input_direction_select && !reg_wr_en |=> drive_brake == $past(feedback_brake_req))
        else $error("unidirectional brake wrong");
    bidir_neg_a: assert property (input_direction_select && !reg_wr_en && !loop_closed && play_sample < 8'h80
        |=> drive_negative && drive_brake)
        else $error("open loop low input not braking");
endmodule
bind hdc_drive_control_regs hdc_drive_props #(.ERM_STEP_CYC(ERM_STEP_CYC), .ERM_BASE_CYC(ERM_BASE_CYC)) chk (.*);
`default_nettype wire

// >>> verif/test_haptic_drive_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_haptic_drive_control_regs;
    logic        sys_clk, sys_rst, reg_wr_en, reg_rd_en, actuator_is_lra, loop_closed, lra_period_valid;
    logic        feedback_brake_req, overdrive_gain_boost, input_common_mode_bias, input_direction_select;
    logic        drive_tick, drive_negative, drive_brake;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, play_sample, drive_magnitude;
    logic [23:0] lra_period_meas, drive_time_cyc;
    int          mismatches, num_checks;
    // Small step counts keep the tick measurement short
    hdc_drive_control_regs #(.LRA_STEP_CYC(10), .LRA_BASE_CYC(50), .ERM_STEP_CYC(20), .ERM_BASE_CYC(100)) uut (.*);
    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // Access and compare tasks
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_wr_en, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge sys_clk) reg_wr_en <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk) {reg_rd_en, reg_addr} <= {1'h1, a};
        @(posedge sys_clk) reg_rd_en <= 1'h0;
        @(posedge sys_clk) #1 chk(reg_rdata, e);
    endtask
    task pl(input logic [7:0] s, input logic [7:0] m, input logic n, input logic b);
        @(posedge sys_clk) play_sample <= s;
        repeat (2) @(posedge sys_clk);
        #1 chk(drive_magnitude, m);
        chk(drive_negative, n);
        chk(drive_brake, b);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Skips the tick in progress, since the timer may still hold the old interval
    task tick_gap(input logic [23:0] e);
        int n;
        int m;
        n = 0;
        while (drive_tick !== 1'h1 && n < 2000) begin
            @(posedge sys_clk) #1 n++;
        end
        m = 0;
        do begin
            @(posedge sys_clk) #1 m++;
        end while (drive_tick !== 1'h1 && m < 2000);
        if (n >= 2000 || drive_tick !== 1'h1) begin
            mismatches++;
            tally_and_finish;
        end else begin
            chk(m, e);
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {mismatches, num_checks} = 0;
        {sys_rst, actuator_is_lra, reg_wr_en, reg_rd_en, loop_closed, lra_period_valid} = 6'h30;
        {reg_addr, reg_wdata, lra_period_meas, feedback_brake_req, play_sample} = 0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'h0;
        rd(8'h1B, 8'h93);
        rd(8'h1C, 8'hF5);
        chk(drive_time_cyc, 24'h0000F0);
        wr(8'h1B, 8'h25);
        chk(overdrive_gain_boost, 1'h0);
        chk(input_common_mode_bias, 1'h1);
        chk(drive_time_cyc, 24'h000064);
        wr(8'h1B, 8'hFF);
        rd(8'h1B, 8'hBF);
        chk(drive_time_cyc, 24'h000168);
        @(posedge sys_clk) {lra_period_valid, lra_period_meas} <= {1'h1, 24'h00012C};
        @(posedge sys_clk) lra_period_valid <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk(drive_time_cyc, 24'h000096);
        @(posedge sys_clk) actuator_is_lra <= 1'h0;
        wr(8'h1B, 8'h1F);
        chk(drive_time_cyc, 24'h0002D0);
        tick_gap(24'h0002D0);
        rd(8'h00, 8'h00);
        pl(8'h40, 8'h80, 1'h1, 1'h1);
        pl(8'hC0, 8'h80, 1'h0, 1'h0);
        pl(8'h00, 8'hFF, 1'h1, 1'h1);
        @(posedge sys_clk) {loop_closed, feedback_brake_req} <= 2'h3;
        pl(8'h40, 8'h00, 1'h0, 1'h1);
        wr(8'h1C, 8'h75);
        rd(8'h1C, 8'h75);
        chk(input_direction_select, 1'h0);
        pl(8'h80, 8'h80, 1'h0, 1'h1);
        @(posedge sys_clk) feedback_brake_req <= 1'h0;
        pl(8'hFF, 8'hFF, 1'h0, 1'h0);
        pl(8'h00, 8'h00, 1'h0, 1'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
